// File: dioev_pkg.sv
// Purpose: Shared constants for the 48-line digital I/O event bank block.
// Assumes: Byte offsets are odd, so bit 0 of an offset is not decoded.
// Notes:   Offsets are bus byte addresses relative to the module base.
package dioev_pkg;

  // ---------------------------------------------------------------
  // Sizes
  // ---------------------------------------------------------------
  localparam int NUM_PORTS = 6;
  localparam int NUM_LINES = 48;
  localparam int NUM_NIBBLES = 12;
  localparam int ADDR_W = 7;

  // ---------------------------------------------------------------
  // Register offsets (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [6:0] OFF_PORT0 = 7'h01;
  localparam logic [6:0] OFF_PORT6 = 7'h0D;
  localparam logic [6:0] OFF_PORT7 = 7'h0F;
  localparam logic [6:0] OFF_INT_EN = 7'h1F;
  localparam logic [6:0] OFF_VECTOR = 7'h2F;
  localparam logic [6:0] OFF_VECTOR_ALIAS = 7'h6F;

  // ---------------------------------------------------------------
  // Field positions and codes
  // ---------------------------------------------------------------
  localparam int MASK_W = 6;
  localparam int BANK_LSB = 6;
  localparam int SUMMARY_BIT = 7;
  localparam int POL_HI_W = 4;
  localparam int INT_EN_BIT = 0;
  localparam logic [2:0] PORT_IDX6 = 3'h6;
  localparam logic [2:0] PORT_IDX7 = 3'h7;
  localparam logic [1:0] BANK_IO = 2'h0;
  localparam logic [1:0] BANK_EVENT = 2'h1;
  localparam logic [1:0] BANK_DEBOUNCE = 2'h2;

  // ---------------------------------------------------------------
  // Unlock byte sequence
  // ---------------------------------------------------------------
  localparam logic [7:0] UNLOCK_B0 = 8'h07;
  localparam logic [7:0] UNLOCK_B1 = 8'h0D;
  localparam logic [7:0] UNLOCK_B2 = 8'h06;
  localparam logic [7:0] UNLOCK_B3 = 8'h12;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [47:0] OUT_RESET = 48'h0;
  localparam logic [5:0] MASK_RESET = 6'h0;
  localparam logic [1:0] BANK_RESET = 2'h0;
  localparam logic [7:0] VECTOR_RESET = 8'h00; // Arbitrary value.

  // Mode-select sequencer states.
  typedef enum logic [5:0] {
    UNL_WAIT0 = 6'b000001,
    UNL_WAIT1 = 6'b000010,
    UNL_WAIT2 = 6'b000100,
    UNL_WAIT3 = 6'b001000,
    UNL_ENH = 6'b010000,
    UNL_LOCKED = 6'b100000
  } dioev_unl_t;

endpackage : dioev_pkg

// File: dioev_regs.sv
// Purpose: Register logic of a 48-line open-drain I/O bank with events.
// Assumes: One access per select pulse; select drops after acknowledge.
// Notes:   Debounce bank storage is not held here and reads as zero.
//
// Behaviour
// R1: Upper data byte is never driven on reads.
// R2: Reads of unused addresses return zero on the driven byte.
// R3: Every access completes with no wait states.
// R4: Interrupt vector register also answers at offset 0x6F.
// R5: Data bit 0 maps to the lowest line of each port.
// R6: Port write sets open-drain drivers; read returns line on/off state.
// R7: Reset clears all output registers, releasing every line.
// R8: Mask bit n blocks writes to port n; mask reads back.
// R9: Host masks every port used as input.
// R10: Reset clears the mask; standard mode ignores mask bits 6 and 7.
// R11: Host writes four unlock bytes to port 7 right after reset.
// R12: Enhanced mode only after 07, 0D, 06, 12 in order on port 7.
// R13: Enhanced port 7 bits 7:6 select bank and read back.
// R14: Host never writes bank code 11.
// R15: Reset gives standard mode, clear mask and bank zero.
// R16: Bank one port reads return each line's event flip-flop.
// R17: Bank one write of zero clears that line's event flip-flop.
// R18: A cleared event input stays disabled until a one is written.
// R19: Bank one port 6 reports per-port status and any-event bit 7.
// R20: Summary flag may drive the carrier interrupt request line.
// R21: Each polarity bit sets rising or falling sense for four lines.
// R22: No interrupt request unless the interrupt enable is set.
// R23: Host sets polarity before enabling event inputs.
// R24: Enabled event flip-flop sets on first edge and holds until cleared.
module dioev_regs
  import dioev_pkg::*;
(
  input wire logic REF_CLK_I, // Bus clock, 100 MHz.
  input wire logic RST_I, // Asynchronous reset, active high.
  input wire logic SEL_N_I, // Register select, active low.
  input wire logic WRITE_I, // High for write, low for read.
  input wire logic [dioev_pkg::ADDR_W-1:0] ADDR_I, // Byte address.
  input wire logic [15:0] DATA_I, // Write data, low byte used.
  output logic [15:0] DATA_O, // Read data.
  output logic DATA_LO_OE_N_O, // Low byte drive enable, active low.
  output logic DATA_HI_OE_N_O, // High byte drive enable, never low.
  output logic ACK_N_O, // Access acknowledge, active low.
  output logic INT_REQ_N_O, // Interrupt request, active low.
  input wire logic [dioev_pkg::NUM_LINES-1:0] IO_I, // Line levels.
  output logic [dioev_pkg::NUM_LINES-1:0] IO_O, // Driven level, low.
  output logic [dioev_pkg::NUM_LINES-1:0] IO_OE_N_O // Pull low, active low.
);
  import dioev_pkg::*;

  // ---------------------------------------------------------------
  // Helper functions
  // ---------------------------------------------------------------
  // Edge of the configured polarity for one line.
  function automatic logic sense_edge(input logic now, input logic was,
                                      input logic rising);
    begin
      sense_edge = rising ? (now & ~was) : (~now & was);
    end
  endfunction : sense_edge

  // Any-bit reduction of one eight-bit port slice.
  function automatic logic port_any(input logic [47:0] v, input int p);
    begin
      port_any = |v[p*8 +: 8];
    end
  endfunction : port_any

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  logic [47:0] out_reg, out_next;
  logic [5:0] mask_reg, mask_next;
  logic [1:0] bank_reg, bank_next;
  logic [11:0] pol_reg, pol_next;
  logic [47:0] ev_reg, ev_next;
  logic [47:0] en_reg, en_next;
  logic int_en_reg, int_en_next;
  logic [7:0] vec_reg, vec_next;
  dioev_unl_t unl_reg, unl_next;
  logic [47:0] s1_reg, s2_reg, s3_reg, flt_reg, flt_d_reg;
  logic ack_reg;
  logic rd_oe_reg;
  logic [7:0] rdata_reg;
  logic irq_reg;

  // ---------------------------------------------------------------
  // Access decode
  // ---------------------------------------------------------------
  // An access is taken when select is low and no acknowledge stands.
  wire acc = ~SEL_N_I & ~ack_reg; // R3
  wire wr = acc & WRITE_I;
  wire [7:0] wd = DATA_I[7:0];
  wire in_ports = (ADDR_I[6:4] == 3'h0);
  wire [2:0] pidx = ADDR_I[3:1];
  wire is_data_port = in_ports & (pidx < PORT_IDX6);
  wire is_p6 = in_ports & (pidx == PORT_IDX6);
  wire is_p7 = in_ports & (pidx == PORT_IDX7);
  wire is_int_en = (ADDR_I[6:1] == OFF_INT_EN[6:1]);
  wire is_vec = (ADDR_I[6:1] == OFF_VECTOR[6:1]) |
                (ADDR_I[6:1] == OFF_VECTOR_ALIAS[6:1]); // R4
  wire enh = (unl_reg == UNL_ENH);
  wire bank_io = ~enh | (bank_reg == BANK_IO);
  wire bank_ev = enh & (bank_reg == BANK_EVENT);
  wire [5:0] port_status;
  wire summary = |port_status; // R19
  wire [47:0] line_on = ~flt_reg; // R6

  // Per-port event status for the summary register.
  genvar g;
  generate
    for (g = 0; g < NUM_PORTS; g++)
    begin : g_stat
      assign port_status[g] = port_any(ev_reg, g); // R19
    end
  endgenerate

  // ---------------------------------------------------------------
  // Read data selection
  // ---------------------------------------------------------------
  // Unused addresses and unheld debounce registers fall to zero.
  logic [7:0] rd_byte;
  always_comb
  begin
    rd_byte = 8'h00; // R2
    if (is_data_port & bank_io)
      rd_byte = line_on[pidx*8 +: 8]; // R5 R6
    else if (is_data_port & bank_ev)
      rd_byte = ev_reg[pidx*8 +: 8]; // R16
    else if (is_p6 & bank_ev)
      rd_byte = {summary, 1'b0, port_status}; // R19
    else if (is_p7 & ~enh)
      rd_byte = {2'b00, mask_reg}; // R10
    else if (is_p7 & bank_io)
      rd_byte = {bank_reg, mask_reg}; // R8 R13
    else if (is_p7)
      rd_byte = {bank_reg, 6'h00}; // R13
    else if (is_int_en)
      rd_byte = {7'h00, int_en_reg};
    else if (is_vec)
      rd_byte = vec_reg; // R4
  end

  // ---------------------------------------------------------------
  // Register write and event logic
  // ---------------------------------------------------------------
  // Writes update storage; events set their flip-flops with priority.
  always_comb
  begin
    out_next = out_reg;
    mask_next = mask_reg;
    bank_next = bank_reg;
    pol_next = pol_reg;
    int_en_next = int_en_reg;
    vec_next = vec_reg;
    en_next = en_reg;
    ev_next = ev_reg;
    if (wr & is_data_port & bank_io & ~mask_reg[pidx])
      out_next[pidx*8 +: 8] = wd; // R5 R6 R8
    if (wr & is_data_port & bank_ev)
    begin
      ev_next[pidx*8 +: 8] = ev_reg[pidx*8 +: 8] & wd; // R17
      en_next[pidx*8 +: 8] = wd; // R18
    end
    if (wr & is_p6 & bank_ev)
      pol_next[7:0] = wd; // R21
    if (wr & is_p7 & (~enh | bank_io))
      mask_next = wd[MASK_W-1:0]; // R8 R10
    if (wr & is_p7 & bank_ev)
      pol_next[11:8] = wd[POL_HI_W-1:0]; // R21
    if (wr & is_p7 & enh)
      bank_next = wd[BANK_LSB +: 2]; // R13
    if (wr & is_int_en)
      int_en_next = wd[INT_EN_BIT];
    if (wr & is_vec)
      vec_next = wd; // R4
    for (int i = 0; i < NUM_LINES; i++)
    begin
      if (en_reg[i] & sense_edge(flt_reg[i], flt_d_reg[i], pol_reg[i/4]))
        ev_next[i] = 1'b1; // R21 R24
    end
  end

  // ---------------------------------------------------------------
  // Mode-select sequencer
  // ---------------------------------------------------------------
  // Any access other than a port 7 read or the expected port 7 write ends the chance.
  always_comb
  begin
    unl_next = unl_reg;
    case (unl_reg)
      UNL_WAIT0, UNL_WAIT1, UNL_WAIT2, UNL_WAIT3:
      begin
        if (acc & ~is_p7)
          unl_next = UNL_LOCKED; // R12
        else if (wr & is_p7)
        begin
          unl_next = UNL_LOCKED;
          if (unl_reg == UNL_WAIT0 && wd == UNLOCK_B0)
            unl_next = UNL_WAIT1; // R12
          if (unl_reg == UNL_WAIT1 && wd == UNLOCK_B1)
            unl_next = UNL_WAIT2;
          if (unl_reg == UNL_WAIT2 && wd == UNLOCK_B2)
            unl_next = UNL_WAIT3;
          if (unl_reg == UNL_WAIT3 && wd == UNLOCK_B3)
            unl_next = UNL_ENH;
        end
      end
      UNL_ENH: unl_next = UNL_ENH;
      UNL_LOCKED: unl_next = UNL_LOCKED;
      default: unl_next = UNL_LOCKED;
    endcase
  end

  // ---------------------------------------------------------------
  // Storage registers
  // ---------------------------------------------------------------
  // Reset releases all lines and returns to standard mode.
  always_ff @(posedge REF_CLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      out_reg <= OUT_RESET; // R7
      mask_reg <= MASK_RESET; // R10 R15
      bank_reg <= BANK_RESET; // R15
      unl_reg <= UNL_WAIT0; // R15
      pol_reg <= 12'h000;
      ev_reg <= 48'h0;
      en_reg <= 48'h0;
      int_en_reg <= 1'b0;
      vec_reg <= VECTOR_RESET;
    end
    else
    begin
      out_reg <= out_next;
      mask_reg <= mask_next;
      bank_reg <= bank_next;
      unl_reg <= unl_next;
      pol_reg <= pol_next;
      ev_reg <= ev_next;
      en_reg <= en_next;
      int_en_reg <= int_en_next;
      vec_reg <= vec_next;
    end
  end

  // Line inputs pass three stages; a change counts when two agree.
  always_ff @(posedge REF_CLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      s1_reg <= {NUM_LINES{1'b1}};
      s2_reg <= {NUM_LINES{1'b1}};
      s3_reg <= {NUM_LINES{1'b1}};
      flt_reg <= {NUM_LINES{1'b1}};
      flt_d_reg <= {NUM_LINES{1'b1}};
    end
    else
    begin
      s1_reg <= IO_I;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      flt_reg <= (s2_reg & s3_reg) | (flt_reg & (s2_reg ^ s3_reg));
      flt_d_reg <= flt_reg;
    end
  end

  // Bus answer: acknowledge and read byte one cycle after the take.
  always_ff @(posedge REF_CLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      ack_reg <= 1'b0;
      rd_oe_reg <= 1'b0;
      rdata_reg <= 8'h00;
      irq_reg <= 1'b0;
    end
    else
    begin
      ack_reg <= acc; // R3
      rd_oe_reg <= acc & ~WRITE_I;
      rdata_reg <= (acc & ~WRITE_I) ? rd_byte : 8'h00;
      irq_reg <= int_en_reg & summary; // R20 R22
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign DATA_O = {8'h00, rdata_reg};
  assign DATA_LO_OE_N_O = ~rd_oe_reg;
  assign DATA_HI_OE_N_O = 1'b1; // R1
  assign ACK_N_O = ~ack_reg;
  assign INT_REQ_N_O = ~irq_reg; // R20
  assign IO_O = {NUM_LINES{1'b0}};
  assign IO_OE_N_O = ~out_reg; // R6

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (RST_I);

  a_upper_float: assert property (DATA_HI_OE_N_O == 1'b1) // R1
    else $error("Upper data byte driven.");
  a_unused_zero: assert property (acc && !WRITE_I && !in_ports && // R2
      !is_int_en && !is_vec |=> DATA_O[7:0] == 8'h00 && !DATA_LO_OE_N_O)
    else $error("Unused address read not zero.");
  a_zero_wait: assert property (acc |=> !ACK_N_O ##1 ACK_N_O) // R3
    else $error("Access not acknowledged in one cycle.");
  a_vec_alias: assert property (acc && !WRITE_I && // R4
      ADDR_I[6:1] == OFF_VECTOR_ALIAS[6:1] |=> DATA_O[7:0] == $past(vec_reg))
    else $error("Vector alias read wrong.");
  a_port_write: assert property (wr && is_data_port && bank_io && // R6
      !mask_reg[pidx] |=> out_reg[$past(pidx)*8 +: 8] == $past(wd))
    else $error("Port write not stored.");
  a_mask_block: assert property (wr && is_data_port && // R8
      mask_reg[pidx] |=> out_reg == $past(out_reg))
    else $error("Masked port was written.");
  a_unlock_last: assert property ($rose(enh) |-> // R12
      $past(wr && is_p7 && wd == UNLOCK_B3 && unl_reg == UNL_WAIT3))
    else $error("Enhanced mode without unlock byte.");
  a_ev_disarm: assert property (wr && is_data_port && bank_ev |=> // R18
      (en_reg[$past(pidx)*8 +: 8] & ~$past(wd)) == 8'h00)
    else $error("Cleared event input still armed.");
  a_summary_read: assert property (acc && !WRITE_I && is_p6 && // R19
      bank_ev |=> DATA_O[SUMMARY_BIT] == |$past(ev_reg))
    else $error("Summary bit wrong.");
  a_irq_gate: assert property (!INT_REQ_N_O |-> $past(int_en_reg)) // R22
    else $error("Interrupt without enable.");

  c_enter_enh: cover property ($rose(enh));
  c_event_set: cover property (enh && $rose(|ev_reg));
  c_irq: cover property ($fell(INT_REQ_N_O));
  c_masked_wr: cover property (wr && is_data_port && mask_reg[pidx]);

endmodule : dioev_regs

// File: dioev_host.sv
// Purpose: Host bus master and line pull-up model for the I/O bank.
// Assumes: One byte access at a time; select held until acknowledge.
// Notes:   Each line is the wired-and of pull-up, source and device.
module dioev_host
  import dioev_pkg::*;
(
  input wire logic clk_i, // Bus clock.
  input wire logic ack_n_i, // Acknowledge, active low.
  input wire logic [15:0] rdata_i, // Read data.
  input wire logic oe_lo_n_i, // Low byte drive enable.
  input wire logic oe_hi_n_i, // High byte drive enable.
  input wire logic [dioev_pkg::NUM_LINES-1:0] pull_n_i, // Pull enables.
  output logic sel_n_o, // Select, active low.
  output logic write_o, // High for write.
  output logic [dioev_pkg::ADDR_W-1:0] addr_o, // Byte address.
  output logic [15:0] wdata_o, // Write data.
  output logic [dioev_pkg::NUM_LINES-1:0] line_o // Line levels.
);
  timeunit 1ns;
  timeprecision 1ns;
  import dioev_pkg::*;
  logic [NUM_LINES-1:0] ext_drv;

  // -------------------------------------------------------------
  // Lines
  // -------------------------------------------------------------
  // A line reads low when the device or an outside source pulls it.
  assign line_o = ext_drv & pull_n_i;

  // Idle bus and released lines at time zero.
  initial
  begin
    sel_n_o = 1'b1;
    write_o = 1'b0;
    addr_o = 7'h00;
    wdata_o = 16'h0000;
    ext_drv = 48'hFFFFFFFFFFFF;
  end

  // Moves one outside source after a clock edge.
  task automatic set_line(input int idx, input logic v);
    @(posedge clk_i);
    ext_drv[idx] <= v;
  endtask : set_line

  // One byte access; the request holds until acknowledge is sampled.
  task automatic bus_xfer(input logic w, input logic [6:0] a,
    input logic [7:0] d, output logic [7:0] q, output logic [3:0] lat,
    output logic lo, output logic hi);
    int n;
    n = 1;
    lat = 4'h0;
    @(posedge clk_i);
    sel_n_o <= 1'b0;
    write_o <= w;
    addr_o <= a;
    wdata_o <= {8'h00, d};
    @(posedge clk_i);
    while (n <= 8 && lat === 4'h0)
    begin
      @(posedge clk_i);
      if (ack_n_i === 1'b0)
        lat = n[3:0];
      else
        n++;
    end
    q = rdata_i[7:0];
    lo = oe_lo_n_i;
    hi = oe_hi_n_i;
    sel_n_o <= 1'b1;
    addr_o <= ~a;
    wdata_o <= {8'hFF, ~d};
  endtask : bus_xfer
endmodule : dioev_host

// File: tb.sv
// Purpose: Self-checking bench for the I/O bank register logic.
// Assumes: Ack one cycle after take; line changes settle in 5 cycles.
// Notes:   Standard mode runs from a table, enhanced mode by hand.
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import dioev_pkg::*;
  typedef struct {logic w; logic [6:0] a; logic [7:0] d; logic [7:0] e;}
    dioev_row_t;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic sel_n, wr, ack_n, irq_n, oe_lo_n, oe_hi_n;
  logic [6:0] addr;
  logic [15:0] wdata, rdata;
  logic [47:0] io_lvl, io_o, io_oe_n;
  int errors = 0;
  int total_checks = 0;
  dioev_row_t rows [22] = '{
    '{1'b0, 7'h2F, 8'h00, 8'h00}, '{1'b0, 7'h0F, 8'h00, 8'h00},
    '{1'b1, 7'h01, 8'hA5, 8'h00}, '{1'b0, 7'h0F, 8'h00, 8'h00},
    '{1'b0, 7'h11, 8'h00, 8'h00}, '{1'b0, 7'h01, 8'h00, 8'hA5},
    '{1'b1, 7'h0F, 8'h02, 8'h00}, '{1'b0, 7'h0F, 8'h00, 8'h02},
    '{1'b1, 7'h03, 8'hFF, 8'h00}, '{1'b0, 7'h03, 8'h00, 8'h00},
    '{1'b1, 7'h0F, 8'hC2, 8'h00}, '{1'b0, 7'h0F, 8'h00, 8'h02},
    '{1'b1, 7'h2F, 8'h3C, 8'h00}, '{1'b0, 7'h6F, 8'h00, 8'h3C},
    '{1'b0, 7'h7F, 8'h00, 8'h00}, '{1'b1, 7'h0F, 8'h07, 8'h00},
    '{1'b1, 7'h0F, 8'h0D, 8'h00}, '{1'b1, 7'h0F, 8'h06, 8'h00},
    '{1'b1, 7'h0F, 8'h12, 8'h00}, '{1'b0, 7'h0F, 8'h00, 8'h12},
    '{1'b1, 7'h0F, 8'h52, 8'h00}, '{1'b0, 7'h0F, 8'h00, 8'h12}};

  // -------------------------------------------------------------
  // Clock and instances
  // -------------------------------------------------------------
  // The bus clock toggles every 5 ns.
  always #5 clk = ~clk;

  dioev_regs dioev_regs_inst (.REF_CLK_I(clk), .RST_I(rst),
    .SEL_N_I(sel_n), .WRITE_I(wr), .ADDR_I(addr), .DATA_I(wdata),
    .DATA_O(rdata), .DATA_LO_OE_N_O(oe_lo_n), .DATA_HI_OE_N_O(oe_hi_n),
    .ACK_N_O(ack_n), .INT_REQ_N_O(irq_n), .IO_I(io_lvl), .IO_O(io_o),
    .IO_OE_N_O(io_oe_n));
  dioev_host dioev_host_inst (.clk_i(clk), .ack_n_i(ack_n),
    .rdata_i(rdata), .oe_lo_n_i(oe_lo_n), .oe_hi_n_i(oe_hi_n),
    .pull_n_i(io_oe_n), .sel_n_o(sel_n), .write_o(wr), .addr_o(addr),
    .wdata_o(wdata), .line_o(io_lvl));

  // -------------------------------------------------------------
  // Checking tasks
  // -------------------------------------------------------------
  // Byte and flag compares count every check and report mismatches.
  task automatic check_byte(input string nm, input logic [7:0] e,
    input logic [7:0] g);
    total_checks++;
    if (g !== e)
    begin
      errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : check_byte

  task automatic check_bit(input string nm, input logic e, input logic g);
    check_byte(nm, {7'h00, e}, {7'h00, g});
  endtask : check_bit

  task automatic final_report();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : final_report

  // One access; a read is compared with the expected byte.
  task automatic step(input logic w, input logic [6:0] a,
    input logic [7:0] d, input logic [7:0] e);
    logic [7:0] q;
    logic [3:0] lat;
    logic lo, hi;
    dioev_host_inst.bus_xfer(w, a, d, q, lat, lo, hi);
    check_byte("ack delay", 8'h01, {4'h0, lat});
    if (lat === 4'h0)
      final_report();
    if (!w)
    begin
      check_byte("read byte", e, q);
      check_bit("low byte drive", 1'b0, lo);
      check_bit("high byte drive", 1'b1, hi);
    end
  endtask : step

  // Lets a line change pass the input filter.
  task automatic line(input logic v);
    dioev_host_inst.set_line(0, v);
    repeat (6) @(posedge clk);
  endtask : line

  // -------------------------------------------------------------
  // Main sequence
  // -------------------------------------------------------------
  // Standard mode table, a second reset, then enhanced mode by hand.
  initial
  begin
    repeat (10) @(posedge clk);
    check_bit("ack idle", 1'b1, ack_n);
    check_bit("irq idle", 1'b1, irq_n);
    for (int i = 0; i < 6; i++)
      check_byte("released", 8'hFF, io_oe_n[8*i +: 8]);
    rst <= 1'b0;
    repeat (5) @(posedge clk);
    foreach (rows[i])
      step(rows[i].w, rows[i].a, rows[i].d, rows[i].e);
    check_byte("port0 drive", 8'h5A, io_oe_n[7:0]);
    check_byte("port0 level", 8'h00, io_o[7:0]);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    check_byte("port0 reset", 8'hFF, io_oe_n[7:0]);
    rst <= 1'b0;
    repeat (5) @(posedge clk);
    step(1'b1, 7'h0F, UNLOCK_B0, 8'h00);
    step(1'b1, 7'h0F, UNLOCK_B1, 8'h00);
    step(1'b1, 7'h0F, UNLOCK_B2, 8'h00);
    step(1'b1, 7'h0F, UNLOCK_B3, 8'h00);
    step(1'b0, 7'h0F, 8'h00, 8'h12);
    step(1'b1, 7'h0F, 8'h01, 8'h00);
    step(1'b1, 7'h01, 8'hFF, 8'h00);
    check_byte("masked port0", 8'hFF, io_oe_n[7:0]);
    step(1'b1, 7'h0F, 8'h41, 8'h00);
    step(1'b0, 7'h0F, 8'h00, 8'h40);
    step(1'b1, 7'h0D, 8'h00, 8'h00);
    step(1'b1, 7'h01, 8'hFF, 8'h00);
    line(1'b0);
    step(1'b0, 7'h01, 8'h00, 8'h01);
    step(1'b0, 7'h0D, 8'h00, 8'h81);
    check_bit("irq disabled", 1'b1, irq_n);
    step(1'b1, 7'h1F, 8'h01, 8'h00);
    step(1'b0, 7'h1F, 8'h00, 8'h01);
    repeat (3) @(posedge clk);
    check_bit("irq enabled", 1'b0, irq_n);
    line(1'b1);
    step(1'b0, 7'h01, 8'h00, 8'h01);
    step(1'b1, 7'h01, 8'hFE, 8'h00);
    step(1'b0, 7'h01, 8'h00, 8'h00);
    step(1'b0, 7'h0D, 8'h00, 8'h00);
    check_bit("irq cleared", 1'b1, irq_n);
    step(1'b1, 7'h0D, 8'h01, 8'h00);
    line(1'b0);
    line(1'b1);
    step(1'b0, 7'h01, 8'h00, 8'h00);
    step(1'b1, 7'h01, 8'hFF, 8'h00);
    line(1'b0);
    step(1'b0, 7'h01, 8'h00, 8'h00);
    line(1'b1);
    step(1'b0, 7'h01, 8'h00, 8'h01);
    step(1'b1, 7'h0F, 8'h80, 8'h00);
    step(1'b0, 7'h0F, 8'h00, 8'h80);
    step(1'b0, 7'h01, 8'h00, 8'h00);
    step(1'b1, 7'h0F, 8'h00, 8'h00);
    step(1'b0, 7'h0F, 8'h00, 8'h01);
    final_report();
  end
endmodule : tb
